// ==== hw/fps_pkg.sv ====
// Package: constants for the flash programmer-side controller
package fps_pkg;
  // Register offsets (AXI4-Lite, byte addresses)
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // Command codes written to REG_CMD
  localparam logic [3:0] CMD_RESET    = 4'h1;
  localparam logic [3:0] CMD_UNPROT   = 4'h2;
  localparam logic [3:0] CMD_VERIFY   = 4'h3;
  localparam logic [3:0] CMD_SEC_ON   = 4'h4;
  localparam logic [3:0] CMD_SEC_OFF  = 4'h5;
  localparam logic [3:0] CMD_READ     = 4'h6;
  localparam logic [3:0] CMD_BLK_ERS  = 4'h7;
  // Field positions in REG_CMD
  localparam int CMD_LSB   = 0;
  localparam int FSE_BIT   = 8;
  // Status bit positions
  localparam int ST_BUSY   = 0;
  localparam int ST_POLL   = 1;
  localparam int ST_TOUT   = 2;
  localparam int ST_EWIN   = 3;
  localparam int ST_RDY    = 4;
  localparam int ST_FAIL   = 5;
  // Command-cycle addresses and data (upper byte always zero)
  localparam logic [17:0] A_5555 = 18'h1_5555;
  localparam logic [17:0] A_AAAA = 18'h2_AAAA;
  localparam logic [17:0] A_ZERO = 18'h0_0000;
  localparam logic [15:0] D_AA   = 16'h00AA;
  localparam logic [15:0] D_55   = 16'h0055;
  localparam logic [15:0] D_F0   = 16'h00F0;
  localparam logic [15:0] D_A0   = 16'h00A0;
  localparam logic [15:0] D_80   = 16'h0080;
  localparam logic [15:0] D_10   = 16'h0010;
  localparam logic [15:0] D_30   = 16'h0030;
  localparam logic [15:0] D_9A   = 16'h009A;
  localparam logic [15:0] D_90   = 16'h0090;
  localparam logic [15:0] D_98   = 16'h0098;
  // Unprotect completion pulse: last data of unprotect sequence
  localparam logic [15:0] D_UNPROT = 16'h009A;
  // Bus-cycle phase length in clocks (strobe low and high time)
  localparam int PHASE_NS  = 100;
  localparam int CLK_NS    = 20;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  // Verify address needs bit zero high and bit five low
  localparam int VFY_B0 = 0;
  localparam int VFY_B5 = 5;
endpackage

// ==== hw/fps_ctrl.sv ====
// Programmer-side controller driving the flash pins from AXI4-Lite
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Requirements from the device document
// RQ1: Device unprotects all blocks after sequence and final strobe pulse.
// RQ2: Protect all blocks before unprotect; restart from protect if cut (no protect sequence here; left to software).
// RQ3: Follow every unprotect with verify-protection.
// RQ4: Verify cycle four reads block address, bit0 high, bit5 low.
// RQ5: Verify leaves read mode; only read/reset or reset restore it.
// RQ6: Device shows status flags on ordinary reads while busy.
// RQ7: Ready/busy valid from final strobe rising edge.
// RQ8: Polling bit inverted while programming, true after.
// RQ9: Polling bit 0 during erase, 1 when done.
// RQ10: Polling bit frozen on failure; judge it with timeout flag.
// RQ11: Poll at programmed address or unprotected erase-target address.
// RQ12: Timeout flag 0 normally, 1 once limit exceeded.
// RQ13: Programming 1 over 0 halts and later sets timeout flag.
// RQ14: After timeout, issue read/reset to leave embedded mode.
// RQ15: Fifty microsecond erase window restarts on each block erase.
// RQ16: Check erase-window flag before and after each extra erase.
// RQ17: Ready/busy pin low while busy or failed, high when ready.
// RQ18: Security-on writes 0x0098 to 0x0000 in cycle four, select low.
// RQ19: Hold security select stable; secured reads return 0x0098.
// RQ20: Security-off is chip erase with select high.
// RQ21: Array failure in security-off leaves security set, locked.
// RQ22: Block erase with select high erases nothing.
// RQ23: Command data written as words with zero upper byte.
module fps_ctrl (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // AXI4-Lite slave
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // Flash pins
  output logic             CE_N,
  output logic             OE_N,
  output logic             WE_N,
  output logic             SECURITY_SELECT,
  output logic [17:0]      ADDR,
  input  wire logic [15:0] DQ_I,
  output logic [15:0]      DQ_O,
  output logic             DQ_OE_N,
  input  wire logic        READY_BUSY_N
);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_SETUP = 4'b0010,
    S_STRB  = 4'b0100,
    S_HOLD  = 4'b1000
  } fps_state_t;

  fps_state_t  state_ff;
  logic [3:0]  cmd_ff;
  logic        fse_ff;
  logic [17:0] addr_ff;
  logic [15:0] data_ff;
  logic [2:0]  step_ff;
  logic [2:0]  nsteps_ff;
  logic [7:0]  cnt_ff;
  logic [15:0] rdata_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic        start_cmd;
  logic        cmd_ok;
  logic        vfy_owed_ff;
  logic        last_rd;
  logic        cyc_rd;
  logic [17:0] cyc_addr;
  logic [15:0] cyc_data;

  // Number of bus cycles for each sequence
  function automatic logic [2:0] seq_len(input logic [3:0] c);
    case (c)
      fps_pkg::CMD_RESET:   seq_len = 3'd1;
      fps_pkg::CMD_UNPROT:  seq_len = 3'd6;
      fps_pkg::CMD_VERIFY:  seq_len = 3'd4;
      fps_pkg::CMD_SEC_ON:  seq_len = 3'd4;
      fps_pkg::CMD_SEC_OFF: seq_len = 3'd6;
      fps_pkg::CMD_READ:    seq_len = 3'd1;
      fps_pkg::CMD_BLK_ERS: seq_len = 3'd6;
      default:              seq_len = 3'd0;
    endcase
  endfunction

  // Address and data of each bus cycle, upper data byte always zero
  always_comb begin
    cyc_rd   = 1'b0;
    cyc_addr = fps_pkg::A_5555;
    cyc_data = fps_pkg::D_AA;
    case (step_ff)
      3'd1: begin
        cyc_addr = fps_pkg::A_AAAA;
        cyc_data = fps_pkg::D_55;
      end
      3'd2: begin
        case (cmd_ff)
          fps_pkg::CMD_VERIFY: cyc_data = fps_pkg::D_90;
          fps_pkg::CMD_SEC_ON: cyc_data = fps_pkg::D_A0;
          fps_pkg::CMD_UNPROT: cyc_data = fps_pkg::D_9A;
          default:             cyc_data = fps_pkg::D_80;
        endcase
      end
      3'd3: begin
        if (cmd_ff == fps_pkg::CMD_VERIFY) begin
          // Block address with bit zero forced high, bit five low
          cyc_rd   = 1'b1; // RQ4
          cyc_addr = addr_ff;
          cyc_addr[fps_pkg::VFY_B0] = 1'b1; // RQ4
          cyc_addr[fps_pkg::VFY_B5] = 1'b0; // RQ4
        end else if (cmd_ff == fps_pkg::CMD_SEC_ON) begin
          cyc_addr = fps_pkg::A_ZERO; // RQ18
          cyc_data = fps_pkg::D_98;   // RQ18
        end
      end
      3'd4: begin
        cyc_addr = fps_pkg::A_AAAA;
        cyc_data = fps_pkg::D_55;
      end
      3'd5: begin
        if (cmd_ff == fps_pkg::CMD_BLK_ERS) begin
          cyc_addr = addr_ff;
          cyc_data = fps_pkg::D_30;
        end else if (cmd_ff == fps_pkg::CMD_UNPROT) begin
          cyc_data = fps_pkg::D_UNPROT; // RQ1
        end else begin
          cyc_data = fps_pkg::D_10; // RQ20
        end
      end
      default: begin
        if (cmd_ff == fps_pkg::CMD_RESET) begin
          cyc_data = fps_pkg::D_F0; // RQ5 RQ14
        end else if (cmd_ff == fps_pkg::CMD_READ) begin
          // Plain read: status flags or secured value come back here
          cyc_rd   = 1'b1; // RQ6 RQ11
          cyc_addr = addr_ff;
        end
      end
    endcase
  end

  assign last_rd   = (step_ff + 3'd1 == nsteps_ff);
  assign start_cmd = aw_got_ff && w_got_ff &&
                     (awaddr_ff == fps_pkg::REG_CMD) &&
                     (state_ff == S_IDLE);
  // After unprotect only verify or read/reset may start a sequence
  assign cmd_ok = !vfy_owed_ff ||
                  (wdata_ff[3:0] == fps_pkg::CMD_VERIFY) ||
                  (wdata_ff[3:0] == fps_pkg::CMD_RESET); // RQ3 RQ14

  // AXI write channel capture; one write outstanding
  assign AWREADY = !aw_got_ff && !BVALID;
  assign WREADY  = !w_got_ff && !BVALID;
  assign BRESP   = 2'b00;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      BVALID    <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got_ff <= 1'b1;
        wdata_ff <= WDATA;
      end
      // Command writes wait until the sequencer is idle
      if (aw_got_ff && w_got_ff &&
          (awaddr_ff != fps_pkg::REG_CMD || state_ff == S_IDLE)) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        BVALID    <= 1'b1;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Software-written address and data registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      addr_ff <= 18'h0_0000;
      data_ff <= 16'h0000;
    end else if (aw_got_ff && w_got_ff) begin
      if (awaddr_ff == fps_pkg::REG_ADDR) begin
        addr_ff <= wdata_ff[17:0];
      end else if (awaddr_ff == fps_pkg::REG_DATA) begin
        data_ff <= wdata_ff[15:0];
      end
    end
  end

  // Verify owed once unprotect starts; no protect sequence lives here,
  // so software must have protected every block beforehand
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      vfy_owed_ff <= 1'b0;
    end else if (start_cmd && wdata_ff[3:0] == fps_pkg::CMD_UNPROT) begin
      vfy_owed_ff <= 1'b1; // RQ2 RQ3
    end else if (start_cmd && wdata_ff[3:0] == fps_pkg::CMD_VERIFY) begin
      vfy_owed_ff <= 1'b0; // RQ3
    end
  end

  // Bus-cycle sequencer; strobe phases last PHASE_CYC clocks each
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff  <= S_IDLE;
      cmd_ff    <= 4'h0;
      fse_ff    <= 1'b0;
      step_ff   <= 3'd0;
      nsteps_ff <= 3'd0;
      cnt_ff    <= 8'h00;
      rdata_ff  <= 16'h0000;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (start_cmd && cmd_ok && seq_len(wdata_ff[3:0]) != 3'd0) begin
            cmd_ff    <= wdata_ff[3:0];
            // Select line held for the whole sequence; low for security-on
            fse_ff    <= wdata_ff[fps_pkg::FSE_BIT] && // RQ18 RQ19 RQ20 RQ22
                         (wdata_ff[3:0] != fps_pkg::CMD_SEC_ON);
            nsteps_ff <= seq_len(wdata_ff[3:0]);
            step_ff   <= 3'd0;
            cnt_ff    <= 8'h00;
            state_ff  <= S_SETUP;
          end
        end
        S_SETUP: begin
          cnt_ff   <= 8'h00;
          state_ff <= S_STRB;
        end
        S_STRB: begin
          if (cnt_ff == 8'(fps_pkg::PHASE_CYC - 1)) begin
            cnt_ff   <= 8'h00;
            state_ff <= S_HOLD;
            if (cyc_rd) begin
              rdata_ff <= DQ_I;
            end
          end else begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
        default: begin
          if (cnt_ff == 8'(fps_pkg::PHASE_CYC - 1)) begin
            if (last_rd) begin
              state_ff <= S_IDLE;
            end else begin
              step_ff  <= step_ff + 3'd1;
              state_ff <= S_SETUP;
            end
          end else begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
      endcase
    end
  end

  // Pin drive; strobe low only in the strobe phase
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CE_N            <= 1'b1;
      OE_N            <= 1'b1;
      WE_N            <= 1'b1;
      ADDR            <= 18'h0_0000;
      DQ_O            <= 16'h0000;
      DQ_OE_N         <= 1'b1;
      SECURITY_SELECT <= 1'b0;
    end else begin
      SECURITY_SELECT <= fse_ff;
      CE_N    <= (state_ff == S_IDLE);
      ADDR    <= cyc_addr;
      DQ_O    <= (cmd_ff == fps_pkg::CMD_READ) ? data_ff : cyc_data; // RQ23
      DQ_OE_N <= !(state_ff != S_IDLE && !cyc_rd);
      WE_N    <= !(state_ff == S_STRB && !cyc_rd);
      OE_N    <= !(state_ff == S_STRB && cyc_rd);
    end
  end

  // AXI read channel; status decodes the read word flags
  assign ARREADY = !RVALID;
  assign RRESP   = 2'b00;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      if (ARADDR == fps_pkg::REG_STATUS) begin
        RDATA <= {26'h000_0000,
                  READY_BUSY_N == 1'b0 && state_ff == S_IDLE &&
                  rdata_ff[5],                     // RQ14 RQ21
                  READY_BUSY_N,                    // RQ17
                  rdata_ff[3],                     // RQ15 RQ16
                  rdata_ff[5],                     // RQ10 RQ12 RQ13
                  rdata_ff[7],                     // RQ8 RQ9
                  state_ff != S_IDLE};
      end else if (ARADDR == fps_pkg::REG_RDATA) begin
        RDATA <= {16'h0000, rdata_ff};
      end else if (ARADDR == fps_pkg::REG_ADDR) begin
        RDATA <= {14'h0000, addr_ff};
      end else if (ARADDR == fps_pkg::REG_DATA) begin
        RDATA <= {16'h0000, data_ff};
      end else begin
        RDATA <= 32'h0000_0000;
      end
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // Write strobe and output enable never low together
  strobe_excl_a: assert property (@(posedge CLK) disable iff (RST) // RQ23
    !(!WE_N && !OE_N)) else $error("strobes overlap");
  // Data bus driven in write strobes, released in read strobes
  dq_drive_a: assert property (@(posedge CLK) disable iff (RST) // RQ23
    (!WE_N |-> !DQ_OE_N) and (!OE_N |-> DQ_OE_N))
    else $error("data bus drive wrong");
  // Verify read drives bit zero high and bit five low
  verify_addr_a: assert property (@(posedge CLK) disable iff (RST) // RQ4
    (!OE_N && cmd_ff == fps_pkg::CMD_VERIFY) |-> (ADDR[0] && !ADDR[5]))
    else $error("bad verify address");
  // Security-on fourth write is 0x0098 at zero, select low
  sec_on_a: assert property (@(posedge CLK) disable iff (RST) // RQ18
    (!WE_N && cmd_ff == fps_pkg::CMD_SEC_ON && step_ff == 3'd3) |->
    (DQ_O == fps_pkg::D_98 && ADDR == fps_pkg::A_ZERO && !SECURITY_SELECT))
    else $error("bad security-on write");
  // Select pin steady while chip select stays low
  fse_stable_a: assert property (@(posedge CLK) disable iff (RST) // RQ19
    (!CE_N && !$past(CE_N)) |-> $stable(SECURITY_SELECT))
    else $error("select moved");
  // Command data upper byte is zero
  upper_zero_a: assert property (@(posedge CLK) disable iff (RST) // RQ23
    (!WE_N && cmd_ff != fps_pkg::CMD_READ) |-> DQ_O[15:8] == 8'h00)
    else $error("upper byte set");
  // A write response follows a taken register write
  bresp_a: assert property (@(posedge CLK) disable iff (RST) // RQ6
    (aw_got_ff && w_got_ff && awaddr_ff != fps_pkg::REG_CMD) |=>
    BVALID) else $error("missing write response");
  // Each write strobe low lasts exactly PHASE_CYC clocks
  we_width_a: assert property (@(posedge CLK) disable iff (RST) // RQ1
    $fell(WE_N) |-> !WE_N [*5] ##1 WE_N)
    else $error("strobe width");
  // Reset sequence writes F0 in its only cycle
  reset_cmd_a: assert property (@(posedge CLK) disable iff (RST) // RQ14
    (!WE_N && cmd_ff == fps_pkg::CMD_RESET) |-> DQ_O == fps_pkg::D_F0)
    else $error("bad reset data");
endmodule

// ==== tb/fps_flash_model.sv ====
// Behavioural flash device as seen by the programmer
`timescale 1ns/1ps
module fps_flash_model #(
  parameter int BUSY_CYC = 300,
  // Block-erase window: 50 us at the 20 ns clock
  parameter int EWIN_CYC = 2500
) (
  // Clock for behavioural timing
  input  wire logic        clk,
  // Programmer-side pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        sec_sel,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] din,
  // Bench control: next operation times out
  input  wire logic        inj_fail,
  // Device outputs
  output logic      [15:0] dout,
  output logic             ready_busy_n
);
  logic        prot = 1'b1;
  logic        secured = 1'b0;
  logic        vfy = 1'b0;
  logic        busy = 1'b0;
  logic        tout = 1'b0;
  logic        ers = 1'b0;
  logic        win = 1'b0;
  logic        un_seen = 1'b0;
  int          wcnt = 0;
  logic        we_d = 1'b1;
  logic [1:0]  op = 2'd0;
  logic [15:0] lastd = 16'h0000;
  logic [15:0] last_out = 16'h0000;
  logic [15:0] val;
  int          cnt = 0;

  task automatic start(input logic [1:0] o, input logic e);
    busy <= 1'b1;
    cnt <= BUSY_CYC;
    op <= o;
    ers <= e;
  endtask

  // Status word while busy, else secured, verify or array word
  always_comb begin
    if (busy)
      val = {8'h00, ~ers & ~lastd[7], 1'b0, tout, 1'b0, ~win, 3'h0};
    else if (secured)
      val = 16'h0098;
    else if (vfy)
      val = (addr[0] & ~addr[5]) ? {15'h0000, prot} : 16'h0000;
    else
      val = addr[15:0] ^ 16'h5A5A;
  end

  // Released bus shows no stale value
  assign dout = (!ce_n && !oe_n) ? val : ~last_out;
  assign ready_busy_n = ~busy;

  // Command decode at strobe rising edge, busy countdown
  always @(posedge clk) begin
    we_d <= we_n;
    if (!ce_n && !oe_n)
      last_out <= val;
    // Erase waits for the window to close before counting down
    if (win) begin
      wcnt <= wcnt - 1;
      if (wcnt == 1)
        win <= 1'b0;
    end else if (busy && cnt > 0)
      cnt <= cnt - 1;
    if (busy && !win && cnt == 1) begin
      if (inj_fail)
        tout <= 1'b1;
      else begin
        busy <= 1'b0;
        if (op == 2'd1)
          secured <= 1'b1;
        if (op == 2'd2)
          secured <= 1'b0;
      end
    end
    if (we_n && !we_d && !ce_n) begin
      lastd <= din;
      if (din == 16'h00F0 && (!busy || tout)) begin
        busy <= 1'b0;
        tout <= 1'b0;
        vfy <= 1'b0;
        un_seen <= 1'b0;
      end else if (!busy || (win && din == 16'h0030)) begin
        case (din)
          16'h009A: begin
            // Third-cycle code arms, sixth-cycle pulse unprotects
            un_seen <= ~un_seen;
            if (un_seen) begin
              prot <= 1'b0;
              start(2'd0, 1'b0);
            end
          end
          16'h0090: vfy <= 1'b1;
          16'h0098: if (addr == 18'h0_0000 && !sec_sel) start(2'd1, 1'b0);
          16'h0010: start(sec_sel ? 2'd2 : 2'd0, 1'b1);
          16'h0030: if (!sec_sel) begin
            // Each further block erase restarts the window
            start(2'd0, 1'b1);
            win <= 1'b1;
            wcnt <= EWIN_CYC;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ==== tb/tb_fps_ctrl.sv ====
// Self-checking bench for the flash programmer controller
`timescale 1ns/1ps
module tb_fps_ctrl;
  logic CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, inj_fail;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CE_N, OE_N, WE_N;
  logic SECURITY_SELECT, DQ_OE_N, READY_BUSY_N;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [17:0] ADDR, a;
  logic [15:0] DQ_I, DQ_O;
  logic [31:0] exp_q[$], msk_q[$];
  int          err_count = 0, num_checks = 0, seed;

  fps_ctrl u_fps_ctrl (.CLK(CLK), .RST(RST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
    .SECURITY_SELECT(SECURITY_SELECT), .ADDR(ADDR), .DQ_I(DQ_I),
    .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .READY_BUSY_N(READY_BUSY_N));

  fps_flash_model u_fps_flash_model (.clk(CLK), .ce_n(CE_N), .oe_n(OE_N),
    .we_n(WE_N), .sec_sel(SECURITY_SELECT), .addr(ADDR), .din(DQ_O),
    .inj_fail(inj_fail), .dout(DQ_I), .ready_busy_n(READY_BUSY_N));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic give_up();
    err_count++;
    report_and_stop();
  endtask

  // Write address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge CLK);
    AWADDR <= ad;
    WDATA <= dt;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) begin
        BREADY <= 1'b0;
        return;
      end
    end
    give_up();
  endtask

  // Read with the expected masked value noted for the monitor
  task automatic rd(input logic [7:0] ad, input logic [31:0] ex,
                    input logic [31:0] mk, output logic [31:0] dv);
    @(posedge CLK);
    exp_q.push_back(ex & mk);
    msk_q.push_back(mk);
    ARADDR <= ad;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) begin
        dv = RDATA;
        RREADY <= 1'b0;
        return;
      end
    end
    give_up();
  endtask

  // Issue a command, then wait until the sequencer is idle again
  task automatic op(input logic [3:0] c, input logic s);
    wr(fps_pkg::REG_CMD, {23'h00_0000, s, 4'h0, c});
    for (int i = 0; i < 60; i++) begin
      rd(fps_pkg::REG_STATUS, 32'h0, 32'h0, d);
      if (d[fps_pkg::ST_BUSY] === 1'b0) return;
    end
    give_up();
  endtask

  // Refresh flags by flash reads until one status bit has a level
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 150; i++) begin
      op(fps_pkg::CMD_READ, 1'b0);
      rd(fps_pkg::REG_STATUS, 32'h0, 32'h0, d);
      if (d[b] === v) return;
    end
    give_up();
  endtask

  // Oldest note compared against each read answer
  always @(posedge CLK)
    if (RVALID === 1'b1 && RREADY === 1'b1 && exp_q.size() > 0) begin
      check(RDATA & msk_q.pop_front(), exp_q.pop_front());
      check({30'h0, RRESP}, 32'h0000_0000);
    end

  // Write answers are always OKAY
  always @(posedge CLK)
    if (BVALID === 1'b1 && BREADY === 1'b1)
      check({30'h0, BRESP}, 32'h0000_0000);

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  initial begin
    {RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, inj_fail} = 7'b100_0000;
    {AWADDR, ARADDR, WDATA, WSTRB} = {48'h0, 4'hF};
    seed = 72;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd(fps_pkg::REG_STATUS, 32'h0, 32'h1, d);
    rd(8'h20, 32'h0, 32'hFFFF_FFFF, d);
    a = 18'($random(seed));
    a[0] = 1'b1;
    a[5] = 1'b0;
    wr(fps_pkg::REG_ADDR, {14'h0000, a});
    // Model starts with every block protected
    op(fps_pkg::CMD_VERIFY, 1'b0);
    rd(fps_pkg::REG_RDATA, 32'h1, 32'h0000_FFFF, d);
    op(fps_pkg::CMD_RESET, 1'b0);
    op(fps_pkg::CMD_UNPROT, 1'b0);
    poll(fps_pkg::ST_RDY, 1'b1);
    // Reads are refused until a verify follows the unprotect
    rd(fps_pkg::REG_RDATA, 32'h1, 32'h0000_FFFF, d);
    op(fps_pkg::CMD_VERIFY, 1'b0);
    rd(fps_pkg::REG_RDATA, 32'h0, 32'h0000_FFFF, d);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_RDATA, 32'h0, 32'h0000_FFFF, d);
    op(fps_pkg::CMD_RESET, 1'b0);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_RDATA, {16'h0000, a[15:0] ^ 16'h5A5A}, 32'h0000_FFFF, d);
    op(fps_pkg::CMD_SEC_ON, 1'b0);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_STATUS, 32'h0, 32'h0000_0016, d);
    poll(fps_pkg::ST_RDY, 1'b1);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_RDATA, 32'h98, 32'h0000_FFFF, d);
    // Failing unsecure: locked, flags report it
    inj_fail <= 1'b1;
    op(fps_pkg::CMD_SEC_OFF, 1'b1);
    poll(fps_pkg::ST_TOUT, 1'b1);
    rd(fps_pkg::REG_STATUS, 32'h24, 32'h0000_0036, d);
    inj_fail <= 1'b0;
    op(fps_pkg::CMD_RESET, 1'b0);
    poll(fps_pkg::ST_RDY, 1'b1);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_RDATA, 32'h98, 32'h0000_FFFF, d);
    op(fps_pkg::CMD_SEC_OFF, 1'b1);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_STATUS, 32'h0, 32'h0000_0012, d);
    poll(fps_pkg::ST_RDY, 1'b1);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_RDATA, {16'h0000, a[15:0] ^ 16'h5A5A}, 32'h0000_FFFF, d);
    op(fps_pkg::CMD_BLK_ERS, 1'b1);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_STATUS, 32'h10, 32'h0000_0010, d);
    // Block erase: window open, a second erase inside it, then erasing
    op(fps_pkg::CMD_BLK_ERS, 1'b0);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_STATUS, 32'h0, 32'h0000_0018, d);
    op(fps_pkg::CMD_BLK_ERS, 1'b0);
    op(fps_pkg::CMD_READ, 1'b0);
    rd(fps_pkg::REG_STATUS, 32'h0, 32'h0000_0008, d);
    poll(fps_pkg::ST_EWIN, 1'b1);
    rd(fps_pkg::REG_STATUS, 32'h08, 32'h0000_001A, d);
    poll(fps_pkg::ST_RDY, 1'b1);
    report_and_stop();
  end
endmodule
